// file: logic/mmv_pkg.sv
// package for the memory map and vector decode block
package mmv_pkg;
  localparam int ADDR_W = 16;
  localparam int EXT_LINES = 8;
  // index of the first and last external interrupt line
  localparam int EXT_IRQ_LINE_FIRST = 0;
  localparam int EXT_IRQ_LINE_LAST = EXT_LINES - 1;
  localparam int SPACE_BYTES = 8192;
  localparam logic [ADDR_W-1:0] REG_LO = 16'h0000;
  localparam logic [ADDR_W-1:0] REG_HI = 16'h003f;
  localparam logic [ADDR_W-1:0] RAM_HI = 16'h017f;
  localparam logic [ADDR_W-1:0] STK_LO = 16'h0100;
  localparam logic [ADDR_W-1:0] STK_HI = 16'h017f;
  // program memory sits at the top 8 Kbytes of the 16-bit space
  localparam logic [ADDR_W-1:0] PROG_LO =
    ADDR_W'(17'h10000 - 17'(SPACE_BYTES));
  localparam logic [ADDR_W-1:0] VEC_LO = 16'hffe0;
  localparam logic [ADDR_W-1:0] UNAS_A_HI = 16'hffed;
  localparam logic [ADDR_W-1:0] UNAS_B_LO = 16'hfff2;
  localparam logic [ADDR_W-1:0] UNAS_B_HI = 16'hfff3;
  // vector pair base addresses, high byte of the pair first
  localparam logic [ADDR_W-1:0] VEC_BUS = 16'hffee;
  localparam logic [ADDR_W-1:0] VEC_SERIAL = 16'hfff0;
  localparam logic [ADDR_W-1:0] VEC_TIMER = 16'hfff4;
  localparam logic [ADDR_W-1:0] VEC_EXT = 16'hfff6;
  localparam logic [ADDR_W-1:0] VEC_SUSP_END = 16'hfff8;
  localparam logic [ADDR_W-1:0] VEC_FLASH = 16'hfffa;
  localparam logic [ADDR_W-1:0] VEC_TRAP = 16'hfffc;
  localparam logic [ADDR_W-1:0] VEC_RESET = 16'hfffe;

  typedef enum {
    SRC_NONE, SRC_RESET, SRC_TRAP, SRC_FLASH, SRC_SUSP_END,
    SRC_EXT, SRC_TIMER, SRC_SERIAL, SRC_BUS
  } mmv_src_t;

  // interrupt requests, all levels held by their sources
  typedef struct packed {
    logic [EXT_LINES-1:0] ext_line;
    logic susp_end;
    logic flash_start;
    logic trap;
    logic bus_ctl;
    logic serial;
    logic timer;
  } mmv_irq_t;

  // region hits for one decoded address
  typedef struct packed {
    logic reg_page;
    logic ram;
    logic stack;
    logic prog;
    logic vec_area;
    logic reserved;
  } mmv_region_t;

  typedef struct packed {
    mmv_region_t region;
    logic [ADDR_W-1:0] vec_addr;
    logic vec_valid;
    logic vec_maskable;
    logic wake;
    logic boot_pend;
  } mmv_state_t;
endpackage

// file: logic/mmv_decode.sv
// address region decode and interrupt vector selection
`timescale 1ns/100ps
// Contract
// - decode covers the 64 Kbyte space
// - RAM 384 bytes, low 64 are registers
// - stack window 0100h to 017Fh
// - top 32 program bytes hold vectors
// - reset fetches FFFEh, unmaskable, wakes halt
// - eight external lines share FFF6h, wake
// - suspend end vectors FFF8h, maskable, wakes
// - flash start vectors FFFAh, maskable, wakes
// - trap vectors FFFCh, unmaskable, no wake
module mmv_decode (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [mmv_pkg::ADDR_W-1:0] cpu_addr,
  input wire mmv_pkg::mmv_irq_t irq_req,
  input wire logic i_mask,
  input wire logic halted,
  input wire logic vec_ack,
  output mmv_pkg::mmv_region_t region,
  output logic [mmv_pkg::ADDR_W-1:0] vec_addr,
  output logic vec_valid,
  output logic vec_maskable,
  output logic wake
);
  mmv_pkg::mmv_state_t st;
  mmv_pkg::mmv_state_t next_st;
  mmv_pkg::mmv_src_t src;
  logic ext_any;
  logic open_ok;

  always_comb begin
    ext_any = |irq_req.ext_line[mmv_pkg::EXT_IRQ_LINE_LAST:
                                mmv_pkg::EXT_IRQ_LINE_FIRST];
    open_ok = !i_mask;
    // fixed priority: higher vector address wins
    if (st.boot_pend) begin
      src = mmv_pkg::SRC_RESET;
    end else if (irq_req.trap) begin
      src = mmv_pkg::SRC_TRAP;
    end else if (open_ok && irq_req.flash_start) begin
      src = mmv_pkg::SRC_FLASH;
    end else if (open_ok && irq_req.susp_end) begin
      src = mmv_pkg::SRC_SUSP_END;
    end else if (open_ok && ext_any) begin
      src = mmv_pkg::SRC_EXT;
    end else if (open_ok && irq_req.timer) begin
      src = mmv_pkg::SRC_TIMER;
    end else if (open_ok && irq_req.serial) begin
      src = mmv_pkg::SRC_SERIAL;
    end else if (open_ok && irq_req.bus_ctl) begin
      src = mmv_pkg::SRC_BUS;
    end else begin
      src = mmv_pkg::SRC_NONE;
    end
  end

  always_comb begin
    next_st = st;
    next_st.region = '0;
    next_st.region.reg_page = cpu_addr <= mmv_pkg::REG_HI;
    next_st.region.ram = cpu_addr > mmv_pkg::REG_HI &&
                         cpu_addr <= mmv_pkg::RAM_HI;
    next_st.region.stack = cpu_addr >= mmv_pkg::STK_LO &&
                           cpu_addr <= mmv_pkg::STK_HI;
    // user code below the vector area
    next_st.region.prog = cpu_addr >= mmv_pkg::PROG_LO &&
                          cpu_addr < mmv_pkg::VEC_LO;
    next_st.region.vec_area = cpu_addr >= mmv_pkg::VEC_LO;
    // flagged only; the response there is not defined
    next_st.region.reserved =
      (cpu_addr > mmv_pkg::RAM_HI && cpu_addr < mmv_pkg::PROG_LO) ||
      // unassigned vector slots count as reserved
      (cpu_addr >= mmv_pkg::VEC_LO && cpu_addr <= mmv_pkg::UNAS_A_HI) ||
      (cpu_addr >= mmv_pkg::UNAS_B_LO && cpu_addr <= mmv_pkg::UNAS_B_HI);

    // ack drops the boot fetch; reset is the only source that sets it
    if (vec_ack) begin
      next_st.boot_pend = 1'b0;
    end
    next_st.vec_valid = src != mmv_pkg::SRC_NONE;
    next_st.vec_maskable = 1'b0;
    next_st.wake = 1'b0;
    unique case (src)
      mmv_pkg::SRC_RESET: begin
        next_st.vec_addr = mmv_pkg::VEC_RESET;
        next_st.wake = halted;
      end
      mmv_pkg::SRC_TRAP: begin
        // trap ignores the mask, never wakes
        next_st.vec_addr = mmv_pkg::VEC_TRAP;
      end
      mmv_pkg::SRC_FLASH: begin
        next_st.vec_addr = mmv_pkg::VEC_FLASH;
        next_st.vec_maskable = 1'b1;
        next_st.wake = halted;
      end
      mmv_pkg::SRC_SUSP_END: begin
        next_st.vec_addr = mmv_pkg::VEC_SUSP_END;
        next_st.vec_maskable = 1'b1;
        next_st.wake = halted;
      end
      mmv_pkg::SRC_EXT: begin
        next_st.vec_addr = mmv_pkg::VEC_EXT;
        next_st.vec_maskable = 1'b1;
        next_st.wake = halted;
      end
      mmv_pkg::SRC_TIMER: begin
        next_st.vec_addr = mmv_pkg::VEC_TIMER;
        next_st.vec_maskable = 1'b1;
      end
      mmv_pkg::SRC_SERIAL: begin
        next_st.vec_addr = mmv_pkg::VEC_SERIAL;
        next_st.vec_maskable = 1'b1;
      end
      mmv_pkg::SRC_BUS: begin
        next_st.vec_addr = mmv_pkg::VEC_BUS;
        next_st.vec_maskable = 1'b1;
      end
      mmv_pkg::SRC_NONE: begin
        // keep the last address so the output does not toggle idly
        next_st.vec_addr = st.vec_addr;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.vec_addr <= mmv_pkg::VEC_RESET;
      st.boot_pend <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign region = st.region;
  assign vec_addr = st.vec_addr;
  assign vec_valid = st.vec_valid;
  assign vec_maskable = st.vec_maskable;
  assign wake = st.wake;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  boot_vector_a: assert property (
    $rose(rst_n) ##1 1'b1 |-> vec_valid && vec_addr == 16'hfffe)
    else $error("reset vector not presented after reset");
  trap_unmasked_a: assert property (
    !st.boot_pend && irq_req.trap |=> vec_valid &&
      vec_addr == 16'hfffc && !wake && !vec_maskable)
    else $error("trap vector wrong or masked");
  mask_blocks_a: assert property (
    i_mask && !st.boot_pend && !irq_req.trap |=> !vec_valid)
    else $error("masked source got a vector");
  ext_wake_a: assert property (
    !st.boot_pend && !irq_req.trap && !i_mask && halted &&
      ext_any && !irq_req.flash_start && !irq_req.susp_end
      |=> vec_addr == 16'hfff6 && wake)
    else $error("external lines did not vector or wake");
  susp_wake_a: assert property (
    !st.boot_pend && !irq_req.trap && !i_mask && halted &&
      irq_req.susp_end && !irq_req.flash_start
      |=> vec_addr == 16'hfff8 && wake)
    else $error("suspend end did not vector or wake");
  flash_vec_a: assert property (
    !st.boot_pend && !irq_req.trap && !i_mask && irq_req.flash_start
      |=> vec_addr == 16'hfffa && wake == $past(halted))
    else $error("flash start vector wrong");
  internal_nowake_a: assert property (
    vec_valid && vec_addr < 16'hfff6 |-> !wake)
    else $error("internal source woke halt");
  unassigned_vec_a: assert property (
    vec_valid |-> !(vec_addr <= 16'hffed || vec_addr == 16'hfff2))
    else $error("vector in unassigned slot");
  stack_window_a: assert property (
    cpu_addr >= 16'h0100 && cpu_addr <= 16'h017f |=>
      region.stack && region.ram && !region.reserved)
    else $error("stack window not decoded");
  reg_page_a: assert property (
    cpu_addr < 16'h0040 |=> region.reg_page && !region.ram)
    else $error("register page not decoded");
  vec_area_a: assert property (
    cpu_addr >= 16'hffe0 |=> region.vec_area && !region.prog)
    else $error("vector area counted as program");
  prog_range_a: assert property (
    cpu_addr >= 16'he000 && cpu_addr < 16'hffe0 |=>
      region.prog && !region.reserved && !region.vec_area)
    else $error("program area not decoded");
  reserved_gap_a: assert property (
    cpu_addr > 16'h017f && cpu_addr < 16'he000 |=>
      region.reserved && !region.ram && !region.prog)
    else $error("gap between RAM and program not reserved");
  ram_top_a: assert property (
    cpu_addr >= 16'h0040 && cpu_addr <= 16'h017f |=>
      region.ram && !region.reg_page && !region.reserved)
    else $error("RAM not decoded");
  reset_nomask_a: assert property (
    vec_valid && vec_addr == 16'hfffe |-> !vec_maskable)
    else $error("reset vector marked maskable");
  wake_srcs_mask_a: assert property (
    vec_valid && vec_addr >= 16'hfff6 && vec_addr <= 16'hfffa
      |-> vec_maskable)
    else $error("waking source not marked maskable");
  // idle keeps the last vector so the core sees no glitch
  idle_hold_a: assert property (
    !st.boot_pend && !irq_req.trap && i_mask |=>
      vec_addr == $past(vec_addr) && !wake)
    else $error("vector moved while nothing was selected");
  trap_no_wake_a: assert property (
    vec_valid && vec_addr == 16'hfffc |-> !wake && !vec_maskable)
    else $error("trap vector woke halt or was maskable");
endmodule

// file: tb/mmv_decode_tb.sv
// self-checking bench for the memory map and vector decode block
`timescale 1ns/100ps
module mmv_decode_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [mmv_pkg::ADDR_W-1:0] cpu_addr = 16'h0000;
  mmv_pkg::mmv_irq_t irq_req = '0;
  logic i_mask = 1'b0;
  logic halted = 1'b1;
  logic vec_ack = 1'b0;
  mmv_pkg::mmv_region_t region;
  logic [mmv_pkg::ADDR_W-1:0] vec_addr;
  logic vec_valid;
  logic vec_maskable;
  logic wake;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  // region edges: first and last byte of each area
  logic [15:0] a_tab [15] = '{16'h0000, 16'h003f, 16'h0040, 16'h00ff,
    16'h0100, 16'h017f, 16'h0180, 16'hdfff, 16'he000, 16'hffdf,
    16'hffe0, 16'hffee, 16'hfff2, 16'hfff4, 16'hffff};
  logic [5:0] r_tab [15] = '{6'h20, 6'h20, 6'h10, 6'h10, 6'h18, 6'h18,
    6'h01, 6'h01, 6'h04, 6'h04, 6'h03, 6'h02, 6'h03, 6'h02, 6'h02};
  // one source each: first ext, last ext, suspend end, flash, trap,
  // bus, serial, timer
  logic [13:0] s_tab [8] = '{14'h0040, 14'h2000, 14'h0020, 14'h0010,
    14'h0008, 14'h0004, 14'h0002, 14'h0001};
  logic [15:0] v_tab [8] = '{16'hfff6, 16'hfff6, 16'hfff8, 16'hfffa,
    16'hfffc, 16'hffee, 16'hfff0, 16'hfff4};
  logic [7:0] msk_v = 8'hef;
  logic [7:0] wk_v = 8'h0f;

  mmv_decode dut (.mclk(mclk), .rst_n(rst_n), .cpu_addr(cpu_addr),
    .irq_req(irq_req), .i_mask(i_mask), .halted(halted),
    .vec_ack(vec_ack), .region(region), .vec_addr(vec_addr),
    .vec_valid(vec_valid), .vec_maskable(vec_maskable), .wake(wake));

  always #4 mclk = ~mclk;

  // whole run is well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  task give_verdict;
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task do_reset(input logic h);
    @(posedge mclk);
    rst_n <= 1'b0;
    halted <= h;
    irq_req <= '0;
    repeat (10) @(posedge mclk);
    #1;
    chk(16'(region), 16'h0000);
    chk(vec_valid, 16'h0000);
    @(posedge mclk);
    rst_n <= 1'b1;
    // vector is offered even with the mask bit set
    i_mask <= 1'b1;
    @(posedge mclk);
    #1;
    chk(vec_valid, 16'h0001);
    chk(vec_addr, 16'hfffe);
    chk(vec_maskable, 16'h0000);
    chk(wake, 16'(h));
    @(posedge mclk);
    vec_ack <= 1'b1;
    @(posedge mclk);
    vec_ack <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(vec_valid, 16'h0000);
  endtask

  task decode_scan;
    for (int i = 0; i < 15; i++) begin
      @(posedge mclk);
      cpu_addr <= a_tab[i];
      @(posedge mclk);
      #1;
      chk(16'(region), 16'(r_tab[i]));
    end
  endtask

  task vec_scan(input logic m, input logic h);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      i_mask <= m;
      halted <= h;
      irq_req <= mmv_pkg::mmv_irq_t'(s_tab[i]);
      @(posedge mclk);
      #1;
      chk(vec_valid, 16'(!(m && msk_v[i])));
      chk(wake, 16'(wk_v[i] && !m && h));
      if (!m) begin
        chk(vec_addr, v_tab[i]);
        chk(vec_maskable, 16'(msk_v[i]));
      end
    end
    @(posedge mclk);
    irq_req <= '0;
    @(posedge mclk);
    #1;
    chk(vec_valid, 16'h0000);
  endtask

  // several sources at once, highest first
  task prio_check;
    logic [13:0] p [4];
    logic [15:0] e [4];
    p = '{14'h3fff, 14'h3ff7, 14'h0007, 14'h0006};
    e = '{16'hfffc, 16'hfffa, 16'hfff4, 16'hfff0};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      i_mask <= 1'b0;
      irq_req <= mmv_pkg::mmv_irq_t'(p[i]);
      @(posedge mclk);
      #1;
      chk(vec_addr, e[i]);
    end
  endtask

  initial begin
    do_reset(1'b1);
    decode_scan();
    vec_scan(1'b0, 1'b1);
    vec_scan(1'b1, 1'b1);
    vec_scan(1'b0, 1'b0);
    prio_check();
    do_reset(1'b0);
    give_verdict();
  end
endmodule
